// [src/rfe_params.svh]
// Constants of the serial command frame engine: frame bytes, sizes, timing.
// Assumes inclusion by bare name from any file that needs them.
`ifndef RFE_PARAMS_SVH
`define RFE_PARAMS_SVH

// Frame markers and identifiers
`define RFE_PREAMBLE 8'h48
`define RFE_START_MARK 8'h02
`define RFE_END_MARK 8'h49
`define RFE_ID_DEVICE 8'h01
`define RFE_ID_HOST 8'h02
`define RFE_FILLER 8'h00

// Size byte limits, counted start marker through end marker
`define RFE_SIZE_MIN 8'h07
`define RFE_SIZE_MAX 8'h11
`define RFE_RSP_SIZE 8'h11
`define RFE_PAYLOAD_MAX 10

// Byte positions inside an outgoing frame
`define RFE_POS_PAYLOAD 5'h07
`define RFE_POS_LAST 5'h11

// Timing: system clock and line rate
`define RFE_CLK_HZ 125000000
`define RFE_BAUD 4800
`define RFE_BIT_CYCLES ((`RFE_CLK_HZ + `RFE_BAUD / 2) / `RFE_BAUD)

// Response buffer depth
`define RFE_FIFO_DEPTH 8

`endif

// [src/rfe_pkg.sv]
// Types of the serial command frame engine.
// Assumes nothing beyond a SystemVerilog compiler.
package rfe_pkg;

   // Receive parser states, Gray along the byte order of a frame
   typedef enum logic [3:0] {
      RFE_RX_IDLE = 4'h0,
      RFE_RX_START = 4'h1,
      RFE_RX_SIZE = 4'h3,
      RFE_RX_SENDER = 4'h2,
      RFE_RX_RECEIVER = 4'h6,
      RFE_RX_CMD_HI = 4'h7,
      RFE_RX_CMD_LO = 4'h5,
      RFE_RX_DATA = 4'h4,
      RFE_RX_END = 4'hc
   } rfe_rx_state_e;

   // Transmit sequencer states
   typedef enum logic [1:0] {
      RFE_TX_IDLE = 2'b00,
      RFE_TX_FETCH = 2'b01,
      RFE_TX_SHIFT = 2'b11
   } rfe_tx_state_e;

endpackage

// [src/rfe_fifo.sv]
// Small synchronous FIFO holding response payload bytes.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module rfe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   output logic [WIDTH-1:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   // Flags are flops so both ready and valid come out registered
   assign push = i_wr_valid && o_wr_ready;
   assign pop = i_rd_ready && o_rd_valid;
   assign o_rd_data = mem_reg[rd_ptr_reg];

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_wr_data;
      end
   end

   // Pointers and level; pointers wrap since depth is a power of two
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         o_wr_ready <= 1'b1;
         o_rd_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         o_wr_ready <= (count_next != (AW+1)'(DEPTH));
         o_rd_valid <= (count_next != '0);
      end
   end
endmodule

// [src/rfe_frame_engine.sv]
// Command frame engine behind an 8N1 serial line on half-duplex RS485.
// Assumes I_RXD straight from the line receiver; O_DE drives the line driver.
`timescale 1ns/100ps
`include "rfe_params.svh"
module rfe_frame_engine #(
   parameter int BIT_CYCLES = `RFE_BIT_CYCLES,
   parameter int FIFO_DEPTH = `RFE_FIFO_DEPTH
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_RXD,
   output logic O_TXD,
   output logic O_DE,
   output logic O_CMD_VALID,
   output logic [15:0] O_CMD_CODE,
   output logic [79:0] O_CMD_PAYLOAD,
   output logic [3:0] O_CMD_LEN,
   output logic O_FRAME_ERR,
   input wire logic [7:0] I_RSP_DATA,
   input wire logic I_RSP_VALID,
   output logic O_RSP_READY,
   input wire logic I_RSP_START,
   input wire logic [3:0] I_RSP_LEN,
   output logic O_TX_BUSY
);
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);

   // Byte at a given position of an outgoing response, payload excepted
   function automatic logic [7:0] rsp_byte(input logic [4:0] pos, input logic [15:0] cmd);
      logic [7:0] b;
      b = `RFE_FILLER;
      unique case (pos)
         5'h00: b = `RFE_PREAMBLE;
         5'h01: b = `RFE_START_MARK;
         5'h02: b = `RFE_RSP_SIZE;
         5'h03: b = `RFE_ID_DEVICE;
         5'h04: b = `RFE_ID_HOST;
         5'h05: b = cmd[15:8];
         5'h06: b = cmd[7:0];
         `RFE_POS_LAST: b = `RFE_END_MARK;
         default: b = `RFE_FILLER;
      endcase
      return b;
   endfunction

   // Receive character
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic rx_busy_reg;
   logic [15:0] rx_cnt_reg;
   logic [3:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic rx_byte_vld_reg;

   // Two-flop synchroniser on the line input
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= I_RXD;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // Mid-bit sampling; a start bit that is gone at mid-bit is a glitch
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_busy_reg <= 1'b0;
         rx_cnt_reg <= '0;
         rx_bit_reg <= '0;
         rx_shift_reg <= '0;
         rx_byte_vld_reg <= 1'b0;
      end else begin
         rx_byte_vld_reg <= 1'b0;
         if (!rx_busy_reg) begin
            if (!rx_sync_reg) begin
               rx_busy_reg <= 1'b1;
               rx_cnt_reg <= HALF_BIT;
               rx_bit_reg <= '0;
            end
         end else if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
         end else begin
            rx_cnt_reg <= BIT_LAST;
            if (rx_bit_reg == 4'h0) begin
               rx_busy_reg <= !rx_sync_reg;
               rx_bit_reg <= 4'h1;
            end else if (rx_bit_reg <= 4'h8) begin
               rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
               rx_bit_reg <= rx_bit_reg + 1'b1;
            end else begin
               // Stop bit; a framing error drops the character
               rx_busy_reg <= 1'b0;
               rx_byte_vld_reg <= rx_sync_reg;
            end
         end
      end
   end

   // Frame parser
   rfe_pkg::rfe_rx_state_e rx_state_reg;
   logic [3:0] rx_data_left_reg;
   logic [3:0] rx_data_idx_reg;
   logic [15:0] rx_cmd_reg;
   logic [79:0] rx_pay_reg;
   logic [7:0] rx_byte;

   assign rx_byte = rx_shift_reg;

   // One byte per step; any mismatch discards and hunts for a preamble
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_state_reg <= rfe_pkg::RFE_RX_IDLE;
         rx_data_left_reg <= '0;
         rx_data_idx_reg <= '0;
         rx_cmd_reg <= '0;
         rx_pay_reg <= '0;
         O_CMD_VALID <= 1'b0;
         O_CMD_CODE <= '0;
         O_CMD_PAYLOAD <= '0;
         O_CMD_LEN <= '0;
         O_FRAME_ERR <= 1'b0;
      end else begin
         O_CMD_VALID <= 1'b0;
         O_FRAME_ERR <= 1'b0;
         if (rx_byte_vld_reg) begin
            unique case (rx_state_reg)
               rfe_pkg::RFE_RX_IDLE: begin
                  if (rx_byte == `RFE_PREAMBLE) begin
                     rx_state_reg <= rfe_pkg::RFE_RX_START;
                  end
               end
               rfe_pkg::RFE_RX_START: begin
                  if (rx_byte == `RFE_START_MARK) begin
                     rx_state_reg <= rfe_pkg::RFE_RX_SIZE;
                  end else begin
                     O_FRAME_ERR <= 1'b1;
                     rx_state_reg <= (rx_byte == `RFE_PREAMBLE) ? rfe_pkg::RFE_RX_START
                                     : rfe_pkg::RFE_RX_IDLE;
                  end
               end
               rfe_pkg::RFE_RX_SIZE: begin
                  // Size covers start, size, ids, two command bytes, end: 7 + data
                  if (rx_byte >= `RFE_SIZE_MIN && rx_byte <= `RFE_SIZE_MAX) begin
                     rx_data_left_reg <= 4'(rx_byte - `RFE_SIZE_MIN);
                     rx_state_reg <= rfe_pkg::RFE_RX_SENDER;
                  end else begin
                     O_FRAME_ERR <= 1'b1;
                     rx_state_reg <= rfe_pkg::RFE_RX_IDLE;
                  end
               end
               rfe_pkg::RFE_RX_SENDER: begin
                  if (rx_byte == `RFE_ID_HOST) begin
                     rx_state_reg <= rfe_pkg::RFE_RX_RECEIVER;
                  end else begin
                     O_FRAME_ERR <= 1'b1;
                     rx_state_reg <= rfe_pkg::RFE_RX_IDLE;
                  end
               end
               rfe_pkg::RFE_RX_RECEIVER: begin
                  if (rx_byte == `RFE_ID_DEVICE) begin
                     rx_state_reg <= rfe_pkg::RFE_RX_CMD_HI;
                  end else begin
                     O_FRAME_ERR <= 1'b1;
                     rx_state_reg <= rfe_pkg::RFE_RX_IDLE;
                  end
               end
               rfe_pkg::RFE_RX_CMD_HI: begin
                  rx_cmd_reg[15:8] <= rx_byte;
                  rx_state_reg <= rfe_pkg::RFE_RX_CMD_LO;
               end
               rfe_pkg::RFE_RX_CMD_LO: begin
                  rx_cmd_reg[7:0] <= rx_byte;
                  rx_pay_reg <= '0;
                  rx_data_idx_reg <= '0;
                  rx_state_reg <= (rx_data_left_reg == '0) ? rfe_pkg::RFE_RX_END
                                  : rfe_pkg::RFE_RX_DATA;
               end
               rfe_pkg::RFE_RX_DATA: begin
                  // First payload byte lands in bits 7:0, order kept for typed values
                  rx_pay_reg[8*rx_data_idx_reg +: 8] <= rx_byte;
                  rx_data_idx_reg <= rx_data_idx_reg + 1'b1;
                  rx_data_left_reg <= rx_data_left_reg - 1'b1;
                  if (rx_data_left_reg == 4'h1) begin
                     rx_state_reg <= rfe_pkg::RFE_RX_END;
                  end
               end
               rfe_pkg::RFE_RX_END: begin
                  rx_state_reg <= rfe_pkg::RFE_RX_IDLE;
                  if (rx_byte == `RFE_END_MARK) begin
                     O_CMD_VALID <= 1'b1;
                     O_CMD_CODE <= rx_cmd_reg;
                     O_CMD_PAYLOAD <= rx_pay_reg;
                     O_CMD_LEN <= rx_data_idx_reg;
                  end else begin
                     O_FRAME_ERR <= 1'b1;
                  end
               end
               default: begin
                  rx_state_reg <= rfe_pkg::RFE_RX_IDLE;
               end
            endcase
         end
      end
   end

   // Response path
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic fifo_wr_ready;

   // Payload bytes wait here; transmitter pace is the back-pressure
   rfe_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rsp_fifo (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_wr_data(I_RSP_DATA),
      .i_wr_valid(I_RSP_VALID),
      .o_wr_ready(fifo_wr_ready),
      .o_rd_data(fifo_data),
      .o_rd_valid(fifo_valid),
      .i_rd_ready(fifo_pop)
   );
   assign O_RSP_READY = fifo_wr_ready;

   rfe_pkg::rfe_tx_state_e tx_state_reg;
   logic [4:0] tx_pos_reg;
   logic [3:0] tx_len_reg;
   logic [15:0] tx_cnt_reg;
   logic [3:0] tx_bits_reg;
   logic [8:0] tx_shift_reg;
   logic tx_from_fifo;

   // Position is inside the value part of the payload
   assign tx_from_fifo = (tx_pos_reg >= `RFE_POS_PAYLOAD) &&
                         (tx_pos_reg < `RFE_POS_PAYLOAD + 5'(tx_len_reg));
   assign fifo_pop = (tx_state_reg == rfe_pkg::RFE_TX_FETCH) && tx_from_fifo && fifo_valid;

   // Frame sequencer and character shifter; start is ignored while busy
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         tx_state_reg <= rfe_pkg::RFE_TX_IDLE;
         tx_pos_reg <= '0;
         tx_len_reg <= '0;
         tx_cnt_reg <= '0;
         tx_bits_reg <= '0;
         tx_shift_reg <= '1;
         O_TXD <= 1'b1;
         O_DE <= 1'b0;
         O_TX_BUSY <= 1'b0;
      end else begin
         unique case (tx_state_reg)
            rfe_pkg::RFE_TX_IDLE: begin
               if (I_RSP_START) begin
                  tx_len_reg <= (I_RSP_LEN > 4'(`RFE_PAYLOAD_MAX)) ?
                                4'(`RFE_PAYLOAD_MAX) : I_RSP_LEN;
                  tx_pos_reg <= '0;
                  O_DE <= 1'b1;
                  O_TX_BUSY <= 1'b1;
                  tx_state_reg <= rfe_pkg::RFE_TX_FETCH;
               end
            end
            rfe_pkg::RFE_TX_FETCH: begin
               // Stalls on an empty buffer while a value byte is due
               if (!tx_from_fifo || fifo_valid) begin
                  tx_shift_reg <= {1'b1, tx_from_fifo ? fifo_data
                                   : rsp_byte(tx_pos_reg, O_CMD_CODE)};
                  O_TXD <= 1'b0;
                  tx_cnt_reg <= BIT_LAST;
                  tx_bits_reg <= 4'h9;
                  tx_state_reg <= rfe_pkg::RFE_TX_SHIFT;
               end
            end
            rfe_pkg::RFE_TX_SHIFT: begin
               if (tx_cnt_reg != '0) begin
                  tx_cnt_reg <= tx_cnt_reg - 1'b1;
               end else if (tx_bits_reg != '0) begin
                  O_TXD <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                  tx_bits_reg <= tx_bits_reg - 1'b1;
                  tx_cnt_reg <= BIT_LAST;
               end else if (tx_pos_reg == `RFE_POS_LAST) begin
                  // Stop bit fully sent; release the line
                  O_DE <= 1'b0;
                  O_TX_BUSY <= 1'b0;
                  tx_state_reg <= rfe_pkg::RFE_TX_IDLE;
               end else begin
                  tx_pos_reg <= tx_pos_reg + 1'b1;
                  tx_state_reg <= rfe_pkg::RFE_TX_FETCH;
               end
            end
            default: begin
               tx_state_reg <= rfe_pkg::RFE_TX_IDLE;
            end
         endcase
      end
   end

   // Text values pass as plain payload; their length is the user's matter
endmodule

// [bench/rfe_host_model.sv]
// Host computer model on the serial line: sends requests, collects replies.
// Assumes its tasks are called from the rising edge of i_clk.
`timescale 1ns/100ps
module rfe_host_model #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic i_clk,
   input wire logic i_txd,
   input wire logic i_de,
   output logic o_rxd
);
   logic [7:0] rx_q[$];
   logic [7:0] rx_byte;

   // Biased line idles high
   initial o_rxd = 1'b1;

   // One character, lsb first; full stop bit so frames may run back to back
   task automatic send_byte(input logic [7:0] b);
      o_rxd <= 1'b0;
      repeat (BIT_CYCLES) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         o_rxd <= b[i];
         repeat (BIT_CYCLES) @(posedge i_clk);
      end
      o_rxd <= 1'b1;
      repeat (BIT_CYCLES) @(posedge i_clk);
   endtask

   // Request frame; bad fields come only from the caller's arguments
   task automatic send_frame(input logic [7:0] snd, rcv, sz, endb,
         input logic [15:0] cmd, input int npl);
      send_byte(8'h48);
      send_byte(8'h02);
      send_byte(sz);
      send_byte(snd);
      send_byte(rcv);
      send_byte(cmd[15:8]);
      send_byte(cmd[7:0]);
      for (int i = 0; i < npl; i++) begin
         send_byte(8'ha0 + 8'(i));
      end
      send_byte(endb);
   endtask

   // Receiver samples mid-bit, only while the device drives the line
   initial begin
      forever begin
         @(posedge i_clk);
         if (i_de === 1'b1 && i_txd === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(posedge i_clk);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYCLES) @(posedge i_clk);
               rx_byte[i] = i_txd;
            end
            repeat (BIT_CYCLES) @(posedge i_clk);
            rx_q.push_back(rx_byte);
         end
      end
   end
endmodule

// [bench/rfe_frame_engine_chk.sv]
// Port-level assertions on the frame engine.
// Assumes one clock domain; bound to every engine instance below.
`timescale 1ns/100ps
module rfe_frame_engine_chk #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_RXD,
   input wire logic O_TXD,
   input wire logic O_DE,
   input wire logic O_CMD_VALID,
   input wire logic [15:0] O_CMD_CODE,
   input wire logic [79:0] O_CMD_PAYLOAD,
   input wire logic [3:0] O_CMD_LEN,
   input wire logic O_FRAME_ERR,
   input wire logic [7:0] I_RSP_DATA,
   input wire logic I_RSP_VALID,
   input wire logic O_RSP_READY,
   input wire logic I_RSP_START,
   input wire logic [3:0] I_RSP_LEN,
   input wire logic O_TX_BUSY
);
   logic [31:0] busy_len_reg;
   logic [31:0] low_len_reg;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);

   // Length of the current busy span
   always_ff @(posedge I_CLK) begin
      busy_len_reg <= (I_SYS_RST || !O_TX_BUSY) ? 32'h0 : busy_len_reg + 32'h1;
   end

   // Length of a low run on the driven line; nine low bits at most
   always_ff @(posedge I_CLK) begin
      low_len_reg <= (I_SYS_RST || !O_DE || O_TXD) ? 32'h0 : low_len_reg + 32'h1;
   end

   sequence s_start_taken;
      I_RSP_START && !O_TX_BUSY;
   endsequence
   sequence s_frame_open;
      (O_DE && O_TX_BUSY) ##1 !O_TXD;
   endsequence

   excl_pulses_a: assert property (!(O_CMD_VALID && O_FRAME_ERR))
      else $error("valid and error pulse together");
   cmd_pulse_a: assert property (O_CMD_VALID |=> !O_CMD_VALID)
      else $error("valid pulse too long");
   err_pulse_a: assert property (O_FRAME_ERR |=> !O_FRAME_ERR)
      else $error("error pulse too long");
   cmd_len_a: assert property (O_CMD_VALID |-> O_CMD_LEN <= 4'ha)
      else $error("payload count above ten");
   cmd_hold_a: assert property (!O_CMD_VALID |-> $stable({O_CMD_CODE, O_CMD_LEN}))
      else $error("command outputs moved without a frame");
   line_idle_a: assert property (!O_DE |-> O_TXD)
      else $error("line not idle high");
   frame_open_a: assert property (s_start_taken |=> s_frame_open)
      else $error("response did not open on time");
   de_busy_a: assert property (O_TX_BUSY |-> O_DE)
      else $error("busy without driver enable");
   frame_len_a: assert property ($fell(O_TX_BUSY) |-> busy_len_reg >= 180 * BIT_CYCLES)
      else $error("response shorter than eighteen characters");
   low_run_a: assert property (low_len_reg <= 9 * BIT_CYCLES)
      else $error("low run longer than start plus eight bits");
endmodule

bind rfe_frame_engine rfe_frame_engine_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
   .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_RXD(I_RXD), .O_TXD(O_TXD), .O_DE(O_DE),
   .O_CMD_VALID(O_CMD_VALID), .O_CMD_CODE(O_CMD_CODE), .O_CMD_PAYLOAD(O_CMD_PAYLOAD),
   .O_CMD_LEN(O_CMD_LEN), .O_FRAME_ERR(O_FRAME_ERR), .I_RSP_DATA(I_RSP_DATA),
   .I_RSP_VALID(I_RSP_VALID), .O_RSP_READY(O_RSP_READY), .I_RSP_START(I_RSP_START),
   .I_RSP_LEN(I_RSP_LEN), .O_TX_BUSY(O_TX_BUSY));

// [bench/tb.sv]
// Self-checking bench: host model on the line, bench on the response side.
// Assumes the checker binds itself; short bit time keeps the run small.
`timescale 1ns/100ps
module tb;
   localparam int BITC = 16;
   logic I_CLK, I_SYS_RST, I_RXD, O_TXD, O_DE, O_CMD_VALID, O_FRAME_ERR;
   logic I_RSP_VALID, O_RSP_READY, I_RSP_START, O_TX_BUSY;
   logic [15:0] O_CMD_CODE;
   logic [79:0] O_CMD_PAYLOAD;
   logic [3:0] O_CMD_LEN, I_RSP_LEN;
   logic [7:0] I_RSP_DATA;
   logic [7:0] rsp_b [12];
   int mismatches, n_tests, n_valid, n_err;

   rfe_frame_engine #(.BIT_CYCLES(BITC)) DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
      .I_RXD(I_RXD), .O_TXD(O_TXD), .O_DE(O_DE), .O_CMD_VALID(O_CMD_VALID),
      .O_CMD_CODE(O_CMD_CODE), .O_CMD_PAYLOAD(O_CMD_PAYLOAD), .O_CMD_LEN(O_CMD_LEN),
      .O_FRAME_ERR(O_FRAME_ERR), .I_RSP_DATA(I_RSP_DATA), .I_RSP_VALID(I_RSP_VALID),
      .O_RSP_READY(O_RSP_READY), .I_RSP_START(I_RSP_START), .I_RSP_LEN(I_RSP_LEN),
      .O_TX_BUSY(O_TX_BUSY));
   rfe_host_model #(.BIT_CYCLES(BITC)) host (.i_clk(I_CLK), .i_txd(O_TXD), .i_de(O_DE),
      .o_rxd(I_RXD));

   // 125 MHz clock
   initial begin
      I_CLK = 1'b0;
      forever #4 I_CLK = ~I_CLK;
   end

   // Pulse counters; pulses last one cycle so each edge is looked at
   always @(posedge I_CLK) begin
      if (O_CMD_VALID === 1'b1) n_valid++;
      if (O_FRAME_ERR === 1'b1) n_err++;
   end

   task automatic chk(input string what, input logic [79:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Shortest request, then the longest with ten payload bytes
   task automatic t_req();
      logic [79:0] pl;
      int v;
      v = n_valid;
      for (int i = 0; i < 10; i++) pl[8*i+:8] = 8'ha0 + 8'(i);
      host.send_frame(8'h02, 8'h01, 8'h07, 8'h49, 16'h303a, 0);
      repeat (4) @(posedge I_CLK);
      chk("valid", 80'(n_valid - v), 80'd1);
      chk("code", 80'(O_CMD_CODE), 80'h303a);
      chk("len", 80'(O_CMD_LEN), 80'd0);
      host.send_frame(8'h02, 8'h01, 8'h11, 8'h49, 16'ha5c3, 10);
      repeat (4) @(posedge I_CLK);
      chk("len", 80'(O_CMD_LEN), 80'd10);
      chk("payload", O_CMD_PAYLOAD, pl);
      host.send_frame(8'h02, 8'h01, 8'h09, 8'h49, 16'ha5c3, 2);
      repeat (4) @(posedge I_CLK);
      chk("text len", 80'(O_CMD_LEN), 80'd2);
      chk("text", O_CMD_PAYLOAD, 80'ha1a0);
      $display("test request done");
   endtask

   // Wrong sender, receiver, size both ways, end; then resync on a good frame
   task automatic t_bad();
      logic [7:0] sd [5] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h02};
      logic [7:0] rv [5] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h01};
      logic [7:0] sz [5] = '{8'h07, 8'h07, 8'h06, 8'h12, 8'h07};
      logic [7:0] en [5] = '{8'h49, 8'h49, 8'h49, 8'h49, 8'h4a};
      int v;
      int e;
      for (int i = 0; i < 5; i++) begin
         v = n_valid;
         e = n_err;
         host.send_frame(sd[i], rv[i], sz[i], en[i], 16'hbeef, 0);
         repeat (4) @(posedge I_CLK);
         chk("err", 80'(n_err - e), 80'd1);
         chk("no valid", 80'(n_valid - v), 80'd0);
      end
      chk("code kept", 80'(O_CMD_CODE), 80'ha5c3);
      host.send_frame(8'h02, 8'h01, 8'h07, 8'h49, 16'h303a, 0);
      repeat (4) @(posedge I_CLK);
      chk("resync", 80'(O_CMD_CODE), 80'h303a);
      $display("test bad frames done");
   endtask

   // Offer rsp_b bytes until n taken or twelve cycles have passed
   task automatic push(input int n, output int k);
      k = 0;
      I_RSP_DATA <= rsp_b[0];
      I_RSP_VALID <= 1'b1;
      for (int i = 0; i < 12 && k < n; i++) begin
         @(posedge I_CLK);
         if (O_RSP_READY === 1'b1) begin
            k++;
            I_RSP_DATA <= rsp_b[k];
         end
      end
      I_RSP_VALID <= 1'b0;
   endtask

   // Send a response of n value bytes and compare all eighteen on the line
   task automatic t_frame(input int n);
      logic [7:0] ex;
      int k;
      host.rx_q.delete();
      I_RSP_LEN <= 4'(n);
      I_RSP_START <= 1'b1;
      @(posedge I_CLK);
      I_RSP_START <= 1'b0;
      repeat (100) @(posedge I_CLK);
      I_RSP_START <= 1'b1; // Refused while busy
      @(posedge I_CLK);
      I_RSP_START <= 1'b0;
      k = 0;
      while (O_TX_BUSY !== 1'b0 && k < 6000) begin
         @(posedge I_CLK);
         k++;
      end
      if (k == 6000) begin
         mismatches++;
         close_out();
      end
      repeat (200) @(posedge I_CLK);
      chk("busy after", 80'(O_TX_BUSY), 80'd0);
      chk("byte count", 80'(host.rx_q.size()), 80'd18);
      for (int i = 0; i < 18; i++) begin
         case (i)
            0: ex = 8'h48;
            1: ex = 8'h02;
            2: ex = 8'h11;
            3: ex = 8'h01;
            4: ex = 8'h02;
            5: ex = 8'h30;
            6: ex = 8'h3a;
            17: ex = 8'h49;
            default: ex = (i - 7 < n) ? rsp_b[i-7] : 8'h00;
         endcase
         chk("tx byte", 80'(host.rx_q[i]), 80'(ex));
      end
   endtask

   // Example value, then fill the buffer until it refuses and drain it
   task automatic t_rsp();
      int k;
      rsp_b[0] = 8'h44;
      rsp_b[1] = 8'he8;
      rsp_b[2] = 8'hdc;
      rsp_b[3] = 8'h98;
      push(4, k);
      t_frame(4);
      for (int i = 0; i < 12; i++) rsp_b[i] = 8'h60 + 8'(i);
      push(10, k);
      chk("fill", 80'(k), 80'd8);
      chk("full", 80'(O_RSP_READY), 80'd0);
      t_frame(8);
      chk("empty", 80'(O_RSP_READY), 80'd1);
      t_frame(0);
      $display("test response done");
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge I_CLK);
      mismatches++;
      close_out();
   end

   initial begin
      I_SYS_RST = 1'b1;
      I_RSP_DATA = 8'h00;
      I_RSP_VALID = 1'b0;
      I_RSP_START = 1'b0;
      I_RSP_LEN = 4'h0;
      mismatches = 0;
      n_tests = 0;
      n_valid = 0;
      n_err = 0;
      repeat (12) @(posedge I_CLK);
      I_SYS_RST <= 1'b0;
      repeat (4) @(posedge I_CLK);
      chk("idle line", 80'({O_TXD, O_DE, O_RSP_READY}), 80'h5);
      t_req();
      t_bad();
      t_rsp();
      close_out();
   end
endmodule
